// File: verilog/access_bank_remap.sv
// How it works
// R1: In indexed literal offset mode, low access offsets map into a window at the base pointer.
// R2: The window spans the pointer value up to the pointer plus 95, i.e. offsets 00h through 5Fh.
// R3: Access-bank offsets above 5Fh use the ordinary access-bank map, untouched by the window.
// R4: Only indexed literal offset operations are relocated, and all others see the plain map.
// R5: With the access bit set, the bank select register picks the bank as with the mode off.
// R6: Ops naming an indirect file operand, the window pointer too, use plain indirect addressing.
// R7: The extended set leaves the bank select register and direct banked addressing unchanged.
// R8: A remapped address is the window pointer plus the low offset, at full data-memory width.
`timescale 1ns/1ps
`default_nettype none
`include "access_bank_remap_cfg.svh"

module access_bank_remap
  import access_bank_remap_pkg::*;
#(
  parameter int ADDR_W = `ABR_ADDR_W,
  parameter int BANK_W = `ABR_BANK_W,
  parameter int OFFS_W = `ABR_OFFS_W
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire logic extended_en,
  input wire logic access_bit,
  input wire logic indirect_op,
  input wire logic [ADDR_W-1:0] indirect_addr,
  input wire logic [OFFS_W-1:0] offset,
  input wire logic [BANK_W-1:0] bank_select_reg,
  input wire logic [ADDR_W-1:0] window_base_pointer,
  output logic addr_valid,
  output logic [ADDR_W-1:0] data_addr,
  output logic window_hit,
  output addr_mode_t addr_mode
);

  logic [ADDR_W-1:0] window_addr;
  logic [ADDR_W-1:0] data_addr_reg, data_addr_next;
  logic addr_valid_reg, addr_valid_next;
  logic window_hit_reg, window_hit_next;
  addr_mode_t mode_reg, mode_next;

  function automatic logic [ADDR_W-1:0] bank_addr(input logic [BANK_W-1:0] bank,
                                                 input logic [OFFS_W-1:0] offs);
    bank_addr = ADDR_W'({bank, offs});
  endfunction

  // The window test and the plain low/high split must agree on the same edge
  function automatic logic low_offset(input logic [OFFS_W-1:0] offs);
    low_offset = (offs <= OFFS_W'(`ABR_WINDOW_TOP));
  endfunction

  window_adder #(.ADDR_W(ADDR_W), .OFFS_W(OFFS_W)) u_add (
    .base(window_base_pointer),
    .offset(offset),
    .sum(window_addr)
  );

  // Decoded once per request and held so the RAM sees a stable address
  always_comb begin
    data_addr_next = data_addr_reg;
    mode_next = mode_reg;
    window_hit_next = window_hit_reg;
    addr_valid_next = req_valid;
    if (req_valid) begin
      window_hit_next = 1'b0;
      if (indirect_op) begin
        data_addr_next = indirect_addr; // R6
        mode_next = MODE_INDIRECT;
      end else if (access_bit) begin
        data_addr_next = bank_addr(bank_select_reg, offset); // R5 R7
        mode_next = MODE_DIRECT_BANKED;
      end else if (extended_en && low_offset(offset)) begin
        data_addr_next = window_addr; // R1 R2 R4 R8
        mode_next = MODE_WINDOW;
        window_hit_next = 1'b1;
      end else if (low_offset(offset)) begin
        data_addr_next = bank_addr(`ABR_ACCESS_LOW_BANK, offset); // R4
        mode_next = MODE_DIRECT_ACCESS;
      end else begin
        data_addr_next = bank_addr(`ABR_ACCESS_HIGH_BANK, offset); // R3
        mode_next = MODE_DIRECT_ACCESS;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      data_addr_reg <= '0;
      mode_reg <= MODE_DIRECT_ACCESS;
      window_hit_reg <= 1'b0;
      addr_valid_reg <= 1'b0;
    end else begin
      data_addr_reg <= data_addr_next;
      mode_reg <= mode_next;
      window_hit_reg <= window_hit_next;
      addr_valid_reg <= addr_valid_next;
    end
  end

  assign data_addr = data_addr_reg;
  assign addr_mode = mode_reg;
  assign window_hit = window_hit_reg;
  assign addr_valid = addr_valid_reg;

  chk_window_sum: assert property (@(posedge clk) disable iff (!reset_n) // R8
    (req_valid && !indirect_op && !access_bit && extended_en && offset <= `ABR_WINDOW_TOP)
    |=> (data_addr == ADDR_W'($past(window_base_pointer) + ADDR_W'($past(offset)))))
    else $error("window address not base plus offset");
  chk_high_offset: assert property (@(posedge clk) disable iff (!reset_n) // R3
    (req_valid && !indirect_op && !access_bit && offset > `ABR_WINDOW_TOP)
    |=> (!window_hit && data_addr == {`ABR_ACCESS_HIGH_BANK, $past(offset)}))
    else $error("high access offset was remapped");
  chk_mode_off: assert property (@(posedge clk) disable iff (!reset_n) // R4
    (req_valid && !extended_en) |=> !window_hit)
    else $error("window used with mode off");
  chk_banked_direct: assert property (@(posedge clk) disable iff (!reset_n) // R5
    (req_valid && !indirect_op && access_bit)
    |=> (data_addr == {$past(bank_select_reg), $past(offset)} && !window_hit))
    else $error("banked access not direct");
  chk_bank_same: assert property (@(posedge clk) disable iff (!reset_n) // R7
    (req_valid && access_bit && !indirect_op) |=> (addr_mode == MODE_DIRECT_BANKED))
    else $error("bank select behaviour changed");
  chk_indirect_plain: assert property (@(posedge clk) disable iff (!reset_n) // R6
    (req_valid && indirect_op) |=> (data_addr == $past(indirect_addr) && !window_hit))
    else $error("indirect access remapped");
  chk_window_span: assert property (@(posedge clk) disable iff (!reset_n) // R2
    (addr_valid && window_hit)
    |-> ($past(offset) <= `ABR_WINDOW_TOP && $past(req_valid)))
    else $error("window hit outside span");
  chk_window_taken: assert property (@(posedge clk) disable iff (!reset_n) // R1
    (req_valid && extended_en && !indirect_op && !access_bit && offset <= `ABR_WINDOW_TOP)
    |=> (window_hit && addr_mode == MODE_WINDOW))
    else $error("low access not relocated");

  // Idle and reset: an idle cycle must not disturb what the RAM is using, and addr_valid follows req_valid
  chk_valid_pulse: assert property (@(posedge clk) disable iff (!reset_n) // R8
    req_valid |=> addr_valid)
    else $error("request gave no address");
  chk_valid_idle: assert property (@(posedge clk) disable iff (!reset_n) // R8
    !req_valid |=> !addr_valid)
    else $error("address flagged with no request");
  chk_addr_held: assert property (@(posedge clk) disable iff (!reset_n) // R8
    !req_valid |=> $stable(data_addr))
    else $error("address moved while idle");
  chk_hit_held: assert property (@(posedge clk) disable iff (!reset_n) // R1
    !req_valid |=> $stable(window_hit))
    else $error("window flag moved while idle");
  chk_mode_held: assert property (@(posedge clk) disable iff (!reset_n) // R4
    !req_valid |=> $stable(addr_mode))
    else $error("mode moved while idle");
  chk_reset_clear: assert property (@(posedge clk) // R4
    !reset_n |=> (!addr_valid && !window_hit && data_addr == '0
                  && addr_mode == MODE_DIRECT_ACCESS))
    else $error("outputs not cleared by reset");

  // Flag and mode must tell the same story, then what a window hit needs and how far it reaches
  chk_hit_is_window: assert property (@(posedge clk) disable iff (!reset_n) // R1
    window_hit |-> (addr_mode == MODE_WINDOW))
    else $error("window flag without window mode");
  chk_window_is_hit: assert property (@(posedge clk) disable iff (!reset_n) // R1
    (addr_mode == MODE_WINDOW) |-> window_hit)
    else $error("window mode without window flag");
  chk_hit_needs_mode: assert property (@(posedge clk) disable iff (!reset_n) // R4
    (addr_valid && window_hit)
    |-> ($past(extended_en) && !$past(indirect_op) && !$past(access_bit)))
    else $error("window hit without indexed literal offset op");
  chk_window_bound: assert property (@(posedge clk) disable iff (!reset_n) // R2
    (addr_valid && window_hit)
    |-> (ADDR_W'(data_addr - $past(window_base_pointer)) <= ADDR_W'(`ABR_WINDOW_TOP)))
    else $error("window address beyond pointer plus top");

  // Access-bank map outside the window, then the window's two ends
  chk_low_direct: assert property (@(posedge clk) disable iff (!reset_n) // R4
    (req_valid && !indirect_op && !access_bit && !extended_en && offset <= `ABR_WINDOW_TOP)
    |=> (data_addr == ADDR_W'({`ABR_ACCESS_LOW_BANK, $past(offset)})
         && addr_mode == MODE_DIRECT_ACCESS))
    else $error("low access offset moved with mode off");
  chk_high_mode: assert property (@(posedge clk) disable iff (!reset_n) // R3
    (req_valid && !indirect_op && !access_bit && offset > `ABR_WINDOW_TOP)
    |=> (addr_mode == MODE_DIRECT_ACCESS))
    else $error("high access offset not direct");
  chk_high_extended: assert property (@(posedge clk) disable iff (!reset_n) // R3
    (req_valid && !indirect_op && !access_bit && extended_en && offset > `ABR_WINDOW_TOP)
    |=> (data_addr == ADDR_W'({`ABR_ACCESS_HIGH_BANK, $past(offset)})))
    else $error("high access offset moved with mode on");
  chk_high_no_hit: assert property (@(posedge clk) disable iff (!reset_n) // R3
    (req_valid && offset > `ABR_WINDOW_TOP) |=> !window_hit)
    else $error("high offset relocated");
  chk_window_top_in: assert property (@(posedge clk) disable iff (!reset_n) // R2
    (req_valid && !indirect_op && !access_bit && extended_en && offset == `ABR_WINDOW_TOP)
    |=> window_hit)
    else $error("top window offset not relocated");
  chk_offset_zero: assert property (@(posedge clk) disable iff (!reset_n) // R1
    (req_valid && !indirect_op && !access_bit && extended_en && offset == '0)
    |=> (data_addr == $past(window_base_pointer)))
    else $error("window does not start at the pointer");

  // Bank select and indirect paths win over the window, then the window wrap
  chk_access_no_hit: assert property (@(posedge clk) disable iff (!reset_n) // R5
    (req_valid && access_bit) |=> !window_hit)
    else $error("banked access relocated");
  chk_banked_wins: assert property (@(posedge clk) disable iff (!reset_n) // R5
    (req_valid && !indirect_op && access_bit && extended_en && offset <= `ABR_WINDOW_TOP)
    |=> (addr_mode == MODE_DIRECT_BANKED))
    else $error("window took a banked access");
  chk_bank_mode_on: assert property (@(posedge clk) disable iff (!reset_n) // R7
    (req_valid && !indirect_op && access_bit && extended_en)
    |=> (data_addr == ADDR_W'({$past(bank_select_reg), $past(offset)})))
    else $error("bank select changed with mode on");
  chk_indirect_mode: assert property (@(posedge clk) disable iff (!reset_n) // R6
    (req_valid && indirect_op) |=> (addr_mode == MODE_INDIRECT))
    else $error("indirect op not indirect");
  chk_indirect_wins: assert property (@(posedge clk) disable iff (!reset_n) // R6
    (req_valid && indirect_op && extended_en && offset <= `ABR_WINDOW_TOP)
    |=> (!window_hit && data_addr == $past(indirect_addr)))
    else $error("window took an indirect op");
  chk_window_wrap: assert property (@(posedge clk) disable iff (!reset_n) // R8
    (addr_valid && window_hit)
    |-> (ADDR_W'(data_addr - $past(window_base_pointer)) == ADDR_W'($past(offset))))
    else $error("window address lost its wrap");
endmodule

`default_nettype wire

// File: verilog/access_bank_remap_cfg.svh
`ifndef ACCESS_BANK_REMAP_CFG_SVH
`define ACCESS_BANK_REMAP_CFG_SVH

// Data memory address width and field layout
`define ABR_ADDR_W 12
`define ABR_BANK_W 4
`define ABR_OFFS_W 8
// Top of the remapped low access range
`define ABR_WINDOW_TOP 8'h5f
// Access RAM bank-0 base for low offsets, top bank for high offsets
`define ABR_ACCESS_LOW_BANK 4'h0
`define ABR_ACCESS_HIGH_BANK 4'hf

`endif

// File: verilog/access_bank_remap_pkg.sv
package access_bank_remap_pkg;
  typedef enum logic [1:0] {
    MODE_DIRECT_ACCESS,
    MODE_DIRECT_BANKED,
    MODE_INDIRECT,
    MODE_WINDOW
  } addr_mode_t;
endpackage

// File: verilog/window_adder.sv
`timescale 1ns/1ps
`default_nettype none
`include "access_bank_remap_cfg.svh"

module window_adder #(
  parameter int ADDR_W = `ABR_ADDR_W,
  parameter int OFFS_W = `ABR_OFFS_W
) (
  input wire logic [ADDR_W-1:0] base,
  input wire logic [OFFS_W-1:0] offset,
  output logic [ADDR_W-1:0] sum
);
  // Wraps at the top of data memory, as the pointer itself does
  assign sum = ADDR_W'(base + ADDR_W'(offset));
endmodule

`default_nettype wire

// File: verif/core_request_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_request_model (
  input wire logic clk,
  output logic req_valid,
  output logic extended_en,
  output logic access_bit,
  output logic indirect_op,
  output logic [11:0] indirect_addr,
  output logic [7:0] offset,
  output logic [3:0] bank_select_reg,
  output logic [11:0] window_base_pointer
);
  initial begin
    {req_valid, extended_en, access_bit, indirect_op, offset} = 12'h0;
    {indirect_addr, bank_select_reg, window_base_pointer} = 28'h0;
    void'($urandom(32'h696a4c51));
    forever begin
      @(posedge clk);
      #1;
      {req_valid, extended_en, access_bit, indirect_op} = 4'($urandom);
      // Half the offsets sit at 5Eh..61h so the window edge is hit often
      offset = ($urandom % 2) ? 8'($urandom % 4) + 8'h5e : 8'($urandom);
      {indirect_addr, bank_select_reg, window_base_pointer} = 28'($urandom);
    end
  end
endmodule
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import access_bank_remap_pkg::*;
  logic clk, reset_n, run, req_valid, extended_en, access_bit, indirect_op;
  logic [11:0] indirect_addr, window_base_pointer, data_addr, e_addr;
  logic [7:0] offset;
  logic [3:0] bank_select_reg;
  logic addr_valid, window_hit, e_valid, e_hit, in_win;
  addr_mode_t addr_mode, e_mode;
  int num_errors = 0;
  int n_tests = 0;
  access_bank_remap access_bank_remap_i (
    .clk(clk),
    .reset_n(reset_n),
    .req_valid(req_valid),
    .extended_en(extended_en),
    .access_bit(access_bit),
    .indirect_op(indirect_op),
    .indirect_addr(indirect_addr),
    .offset(offset),
    .bank_select_reg(bank_select_reg),
    .window_base_pointer(window_base_pointer),
    .addr_valid(addr_valid),
    .data_addr(data_addr),
    .window_hit(window_hit),
    .addr_mode(addr_mode)
  );
  core_request_model core_request_model_i (
    .clk(clk),
    .req_valid(req_valid),
    .extended_en(extended_en),
    .access_bit(access_bit),
    .indirect_op(indirect_op),
    .indirect_addr(indirect_addr),
    .offset(offset),
    .bank_select_reg(bank_select_reg),
    .window_base_pointer(window_base_pointer)
  );
  task automatic check_addr(string name, logic [11:0] exp, logic [11:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_flag(string name, logic exp, logic got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic check_mode(string name, addr_mode_t exp, addr_mode_t got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  assign in_win = extended_en && offset <= 8'h5f;
  // Reference model: one answer per request, held while idle
  always @(posedge clk) begin
    e_valid <= reset_n & req_valid;
    if (!reset_n) begin
      {e_hit, e_addr} <= 13'h0;
      e_mode <= MODE_DIRECT_ACCESS;
    end else if (req_valid) begin
      e_hit <= !indirect_op && !access_bit && in_win;
      e_mode <= indirect_op ? MODE_INDIRECT : access_bit ? MODE_DIRECT_BANKED :
        in_win ? MODE_WINDOW : MODE_DIRECT_ACCESS;
      e_addr <= indirect_op ? indirect_addr : access_bit ? {bank_select_reg, offset} :
        in_win ? 12'((int'(window_base_pointer) + int'(offset)) % 4096) :
        (offset <= 8'h5f) ? {4'h0, offset} : {4'hf, offset};
    end
  end
  // Outputs are looked at mid-cycle, well clear of the launching edge
  always @(negedge clk) begin
    if (run) begin
      check_flag("addr_valid", e_valid, addr_valid);
      check_addr("data_addr", e_addr, data_addr);
      check_flag("window_hit", e_hit, window_hit);
      check_mode("addr_mode", e_mode, addr_mode);
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    reset_n = 1'b0;
    run = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    reset_n = 1'b1;
    run = 1'b1;
    repeat (2000) @(posedge clk);
    $display("Test random request mix done");
    stop_test();
  end
  initial begin
    #30000;
    num_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
